// [design/bsbe_regs.svh]
// Register offsets, field positions, reset values and cycle counts of the execute block.
`ifndef BSBE_REGS_SVH
`define BSBE_REGS_SVH
`define BSBE_ADDR_INSTR 8'h00
`define BSBE_ADDR_OPND 8'h04
`define BSBE_ADDR_PC 8'h08
`define BSBE_ADDR_ZPTR 8'h0c
`define BSBE_ADDR_STACK 8'h10
`define BSBE_ADDR_FLAGS 8'h14
`define BSBE_ADDR_RESULT 8'h18
`define BSBE_F_OP 5:0
`define BSBE_F_BIT 10:8
`define BSBE_F_TWO 11
`define BSBE_F_OFS 27:16
`define BSBE_F_OFS_MSB 27
`define BSBE_F_RD 7:0
`define BSBE_F_RR 15:8
`define BSBE_F_IO 23:16
`define BSBE_F_IMM 31:24
`define BSBE_FL_C 0
`define BSBE_FL_Z 1
`define BSBE_FL_N 2
`define BSBE_FL_V 3
`define BSBE_FL_S 4
`define BSBE_FL_H 5
`define BSBE_FL_T 6
`define BSBE_FL_I 7
`define BSBE_RST_WORD 32'h0000_0000
`define BSBE_RST_PC 16'h0000
`define BSBE_RST_FLAGS 8'h00
`define BSBE_CYC_ALU 3'h1
`define BSBE_CYC_JUMP 3'h2
`define BSBE_CYC_CALL 3'h3
`define BSBE_CYC_RET 3'h4
`define BSBE_CYC_IOBIT 3'h2
`define BSBE_CYC_BR_TAKEN 3'h2
`define BSBE_CYC_SKIP1 3'h2
`define BSBE_CYC_SKIP2 3'h3
`endif

// [design/bsbe_pkg.sv]
// Types shared by the execute block and its flag unit.
package bsbe_pkg;
  typedef enum logic [5:0] {
    op_test_zero_minus, op_register_zero, op_register_all_ones,
    op_relative_jump, op_pointer_jump, op_relative_call, op_pointer_call,
    op_subroutine_return, op_interrupt_return, op_compare_skip_equal,
    op_compare_regs, op_compare_regs_carry, op_compare_immediate,
    op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set,
    op_branch_flag_set, op_branch_flag_clear, op_io_bit_set, op_io_bit_clear,
    op_shift_left_logical, op_shift_right_logical, op_rotate_left_carry, op_rotate_right_carry,
    op_branch_equal, op_branch_not_equal, op_branch_carry_set, op_branch_carry_clear,
    op_branch_same_higher, op_branch_lower, op_branch_minus, op_branch_plus,
    op_branch_signed_ge, op_branch_signed_lt, op_branch_half_carry_set,
    op_branch_half_carry_clear, op_branch_transfer_set, op_branch_transfer_clear,
    op_branch_overflow_set, op_branch_overflow_clear, op_branch_irq_enabled,
    op_branch_irq_disabled
  } bsbe_op_type;
  localparam logic [5:0] BSBE_OP_LAST = op_branch_irq_disabled;
  typedef enum logic {st_idle, st_exec} bsbe_state_type;
endpackage

// [design/bsbe_alu.sv]
// Result and flag unit for the register test, clear, set, compare, shift and rotate operations.
`timescale 1ns/1ps
`include "bsbe_regs.svh"
module bsbe_alu
  import bsbe_pkg::*;
#(
  parameter int W = 8
) (
  input bsbe_op_type op,
  input logic [W-1:0] a,
  input logic [W-1:0] b,
  input logic [7:0] f_in,
  output logic [W-1:0] res,
  output logic [7:0] f_out
);
  if (W < 4) begin : g_width_check
    $error("bsbe_alu needs at least four data bits.");
  end

  logic [W:0] sub;
  logic [W-1:0] diff;
  logic cin;
  logic h_b;
  logic v_b;
  logic c_b;

  assign cin = (op == op_compare_regs_carry) & f_in[`BSBE_FL_C];
  assign sub = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
  assign diff = sub[W-1:0];
  assign h_b = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
  assign v_b = (a[W-1] & ~b[W-1] & ~diff[W-1]) | (~a[W-1] & b[W-1] & diff[W-1]);
  assign c_b = (~a[W-1] & b[W-1]) | (b[W-1] & diff[W-1]) | (diff[W-1] & ~a[W-1]);

  always_comb begin
    res = a;
    f_out = f_in;
    case (op)
      op_test_zero_minus, op_register_zero: begin
        res = (op == op_test_zero_minus) ? (a & a) : (a ^ a);
        f_out[`BSBE_FL_V] = 1'b0;
        f_out[`BSBE_FL_N] = res[W-1];
        f_out[`BSBE_FL_Z] = ~|res;
      end
      op_register_all_ones: begin
        res = '1;
      end
      op_compare_regs, op_compare_regs_carry, op_compare_immediate: begin
        f_out[`BSBE_FL_Z] = ~|diff & ((op != op_compare_regs_carry) | f_in[`BSBE_FL_Z]);
        f_out[`BSBE_FL_N] = diff[W-1];
        f_out[`BSBE_FL_V] = v_b;
        f_out[`BSBE_FL_C] = c_b;
        f_out[`BSBE_FL_H] = h_b;
      end
      op_shift_left_logical, op_shift_right_logical, op_rotate_left_carry, op_rotate_right_carry: begin
        case (op)
          op_shift_left_logical: res = {a[W-2:0], 1'b0};
          op_shift_right_logical: res = {1'b0, a[W-1:1]};
          op_rotate_left_carry: res = {a[W-2:0], f_in[`BSBE_FL_C]};
          default: res = {f_in[`BSBE_FL_C], a[W-1:1]};
        endcase
        f_out[`BSBE_FL_C] = (op == op_shift_left_logical || op == op_rotate_left_carry) ? a[W-1] : a[0];
        f_out[`BSBE_FL_N] = res[W-1];
        f_out[`BSBE_FL_V] = res[W-1] ^ f_out[`BSBE_FL_C];
        f_out[`BSBE_FL_Z] = ~|res;
      end
      default: begin
        res = a;
      end
    endcase
  end
endmodule

// [design/bsbe_execute.sv]
// Branch, skip, bit and shift execute block with an APB register window.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "bsbe_regs.svh"
module bsbe_execute
  import bsbe_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] instr;
  logic [31:0] opnd;
  logic [15:0] pc;
  logic [15:0] zptr;
  logic [15:0] stack;
  logic [7:0] flags;
  logic [7:0] res_last;
  logic [2:0] cyc_last;
  logic taken_last;
  logic rdw_last;
  logic iow_last;
  bsbe_state_type st;
  logic [2:0] count;
  logic [15:0] pend_pc;
  logic [15:0] pend_stack;
  logic [7:0] pend_flags;
  logic [7:0] pend_res;
  logic [7:0] pend_io;
  logic pend_rdw;
  logic pend_iow;

  ////////////////////////////////////////////////////////////////////////////
  // The APB slave answers with one wait state and stalls writes while busy.
  wire hit_instr = paddr == `BSBE_ADDR_INSTR;
  wire hit_opnd = paddr == `BSBE_ADDR_OPND;
  wire hit_pc = paddr == `BSBE_ADDR_PC;
  wire hit_zptr = paddr == `BSBE_ADDR_ZPTR;
  wire hit_stack = paddr == `BSBE_ADDR_STACK;
  wire hit_flags = paddr == `BSBE_ADDR_FLAGS;
  wire hit_result = paddr == `BSBE_ADDR_RESULT;
  wire mapped = hit_instr | hit_opnd | hit_pc | hit_zptr | hit_stack | hit_flags | hit_result;
  wire busy = st == st_exec;
  wire op_ok = pwdata[`BSBE_F_OP] <= BSBE_OP_LAST;
  wire bad = ~mapped | (pwrite & hit_result) | (pwrite & hit_instr & ~op_ok);
  wire waiting = psel & penable & ~pready;
  wire next_pready = waiting & ~(busy & pwrite);
  wire do_write = psel & penable & pready & pwrite & ~pslverr;
  wire accept = do_write & hit_instr;
  wire commit = busy & (count == 3'h1);
  wire [31:0] result_word = {17'h0, iow_last, rdw_last, cyc_last, taken_last, busy, res_last};
  wire [31:0] next_prdata = hit_instr ? instr :
                            hit_opnd ? opnd :
                            hit_pc ? {16'h0, pc} :
                            hit_zptr ? {16'h0, zptr} :
                            hit_stack ? {16'h0, stack} :
                            hit_flags ? {24'h0, flags} :
                            hit_result ? result_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `BSBE_RST_WORD;
    end else begin
      pready <= next_pready;
      pslverr <= next_pready & bad;
      prdata <= (next_pready & ~pwrite) ? next_prdata : `BSBE_RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the instruction word being written.
  bsbe_op_type op_in;
  assign op_in = bsbe_op_type'(pwdata[`BSBE_F_OP]);
  wire [2:0] bitsel = pwdata[`BSBE_F_BIT];
  wire two_word = pwdata[`BSBE_F_TWO];
  wire [15:0] ofs = {{4{pwdata[`BSBE_F_OFS_MSB]}}, pwdata[`BSBE_F_OFS]};
  wire [7:0] rd_v = opnd[`BSBE_F_RD];
  wire [7:0] rr_v = opnd[`BSBE_F_RR];
  wire [7:0] io_v = opnd[`BSBE_F_IO];
  wire [7:0] imm_v = opnd[`BSBE_F_IMM];
  wire [7:0] mask = 8'h01 << bitsel;
  wire [15:0] seq_pc = pc + 16'h0001;
  wire [15:0] rel_target = pc + ofs + 16'h0001;
  wire [15:0] skip_pc = pc + (two_word ? 16'h0003 : 16'h0002);
  wire [2:0] skip_cyc = two_word ? `BSBE_CYC_SKIP2 : `BSBE_CYC_SKIP1;
  wire fl_c = flags[`BSBE_FL_C];
  wire fl_z = flags[`BSBE_FL_Z];
  wire fl_n = flags[`BSBE_FL_N];
  wire fl_v = flags[`BSBE_FL_V];
  wire fl_h = flags[`BSBE_FL_H];
  wire fl_t = flags[`BSBE_FL_T];
  wire fl_i = flags[`BSBE_FL_I];
  wire skip_cond = (op_in == op_compare_skip_equal) ? (rd_v == rr_v) :
                   (op_in == op_skip_reg_bit_clear) ? ~rr_v[bitsel] :
                   (op_in == op_skip_reg_bit_set) ? rr_v[bitsel] :
                   (op_in == op_skip_io_bit_clear) ? ~io_v[bitsel] :
                   (op_in == op_skip_io_bit_set) ? io_v[bitsel] : 1'b0;

  logic is_br;
  logic br;
  always_comb begin
    is_br = 1'b1;
    case (op_in)
      op_branch_flag_set: br = flags[bitsel];
      op_branch_flag_clear: br = ~flags[bitsel];
      op_branch_equal: br = fl_z;
      op_branch_not_equal: br = ~fl_z;
      op_branch_carry_set, op_branch_lower: br = fl_c;
      op_branch_carry_clear, op_branch_same_higher: br = ~fl_c;
      op_branch_minus: br = fl_n;
      op_branch_plus: br = ~fl_n;
      op_branch_signed_ge: br = ~(fl_n ^ fl_v);
      op_branch_signed_lt: br = fl_n ^ fl_v;
      op_branch_half_carry_set: br = fl_h;
      op_branch_half_carry_clear: br = ~fl_h;
      op_branch_transfer_set: br = fl_t;
      op_branch_transfer_clear: br = ~fl_t;
      op_branch_overflow_set: br = fl_v;
      op_branch_overflow_clear: br = ~fl_v;
      op_branch_irq_enabled: br = fl_i;
      op_branch_irq_disabled: br = ~fl_i;
      default: begin
        is_br = 1'b0;
        br = 1'b0;
      end
    endcase
  end

  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  bsbe_alu #(.W(8)) u_alu (
    .op(op_in),
    .a(rd_v),
    .b((op_in == op_compare_immediate) ? imm_v : rr_v),
    .f_in(flags),
    .res(alu_res),
    .f_out(alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Effect of the instruction: next PC, cycles, flags and write-backs.
  logic [15:0] x_pc;
  logic [15:0] x_stack;
  logic [7:0] x_flags;
  logic [7:0] x_io;
  logic [2:0] x_cyc;
  logic x_taken;
  logic x_rdw;
  logic x_iow;
  always_comb begin
    x_pc = seq_pc;
    x_stack = stack;
    x_flags = alu_flags;
    x_io = io_v;
    x_cyc = `BSBE_CYC_ALU;
    x_taken = 1'b0;
    x_rdw = 1'b0;
    x_iow = 1'b0;
    if (is_br && br) begin
      x_taken = 1'b1;
      x_pc = rel_target;
      x_cyc = `BSBE_CYC_BR_TAKEN;
    end
    if (skip_cond) begin
      x_taken = 1'b1;
      x_pc = skip_pc;
      x_cyc = skip_cyc;
    end
    case (op_in)
      op_test_zero_minus, op_register_zero, op_register_all_ones, op_shift_left_logical,
      op_shift_right_logical, op_rotate_left_carry, op_rotate_right_carry: begin
        x_rdw = 1'b1;
      end
      op_relative_jump, op_pointer_jump: begin
        x_pc = (op_in == op_relative_jump) ? rel_target : zptr;
        x_cyc = `BSBE_CYC_JUMP;
      end
      op_relative_call, op_pointer_call: begin
        x_pc = (op_in == op_relative_call) ? rel_target : zptr;
        x_stack = seq_pc;
        x_cyc = `BSBE_CYC_CALL;
      end
      op_subroutine_return, op_interrupt_return: begin
        x_pc = stack;
        x_cyc = `BSBE_CYC_RET;
        x_flags[`BSBE_FL_I] = (op_in == op_interrupt_return) | fl_i;
      end
      op_io_bit_set, op_io_bit_clear: begin
        x_io = (op_in == op_io_bit_set) ? (io_v | mask) : (io_v & ~mask);
        x_iow = 1'b1;
        x_cyc = `BSBE_CYC_IOBIT;
      end
      default: begin
        x_iow = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer holds the effect for the documented number of cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= st_idle;
      count <= 3'h0;
    end else if (accept) begin
      st <= st_exec;
      count <= x_cyc;
    end else if (commit) begin
      st <= st_idle;
      count <= 3'h0;
    end else if (busy) begin
      count <= count - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_pc <= `BSBE_RST_PC;
      pend_stack <= `BSBE_RST_PC;
      pend_flags <= `BSBE_RST_FLAGS;
      pend_res <= 8'h00;
      pend_io <= 8'h00;
      pend_rdw <= 1'b0;
      pend_iow <= 1'b0;
    end else if (accept) begin
      pend_pc <= x_pc;
      pend_stack <= x_stack;
      pend_flags <= x_flags;
      pend_res <= alu_res;
      pend_io <= x_io;
      pend_rdw <= x_rdw;
      pend_iow <= x_iow;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= `BSBE_RST_WORD;
      cyc_last <= 3'h0;
      taken_last <= 1'b0;
    end else if (accept) begin
      instr <= pwdata;
      cyc_last <= x_cyc;
      taken_last <= x_taken;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= `BSBE_RST_PC;
      stack <= `BSBE_RST_PC;
      flags <= `BSBE_RST_FLAGS;
      zptr <= `BSBE_RST_PC;
    end else if (commit) begin
      pc <= pend_pc;
      stack <= pend_stack;
      flags <= pend_flags;
    end else if (do_write) begin
      pc <= hit_pc ? pwdata[15:0] : pc;
      stack <= hit_stack ? pwdata[15:0] : stack;
      flags <= hit_flags ? pwdata[7:0] : flags;
      zptr <= hit_zptr ? pwdata[15:0] : zptr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd <= `BSBE_RST_WORD;
      res_last <= 8'h00;
      rdw_last <= 1'b0;
      iow_last <= 1'b0;
    end else if (commit) begin
      opnd[`BSBE_F_RD] <= pend_rdw ? pend_res : rd_v;
      opnd[`BSBE_F_IO] <= pend_iow ? pend_io : io_v;
      res_last <= pend_res;
      rdw_last <= pend_rdw;
      iow_last <= pend_iow;
    end else if (do_write && hit_opnd) begin
      opnd <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the executed effects.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zero_result: assert property (accept && op_in == op_register_zero |-> ##2
    (opnd[`BSBE_F_RD] == 8'h00 && flags[`BSBE_FL_Z] && !busy)) else $error("Clear did not give zero.");
  a_test_keeps: assert property (accept && op_in == op_test_zero_minus |-> ##2
    (opnd[`BSBE_F_RD] == $past(rd_v, 2) && flags[`BSBE_FL_N] == $past(rd_v[7], 2)))
    else $error("Test changed register or N.");
  a_jump_target: assert property (accept && op_in == op_relative_jump |=> busy ##1 busy
    ##1 (!busy && pc == $past(rel_target, 3) && flags == $past(flags, 3))) else $error("Jump wrong.");
  a_call_three: assert property (accept && op_in == op_pointer_call |=> busy[*3]
    ##1 (!busy && pc == $past(zptr, 4) && stack == $past(seq_pc, 4))) else $error("Call wrong.");
  a_skip_two_word: assert property (accept && op_in == op_compare_skip_equal && rd_v == rr_v && two_word
    |-> ##4 (!busy && pc == $past(pc, 4) + 16'h0003)) else $error("Skip wrong.");
  a_regbit_skip: assert property (accept && op_in == op_skip_reg_bit_set && !skip_cond
    |=> busy ##1 (!busy && pc == $past(pc, 2) + 16'h0001)) else $error("Bit skip wrong.");
  a_branch_untaken: assert property (accept && is_br && !br |-> ##2
    (pc == $past(seq_pc, 2) && flags == $past(flags, 2))) else $error("Untaken branch wrong.");
  a_signed_ge: assert property (accept && op_in == op_branch_signed_ge && !(fl_n ^ fl_v)
    |-> ##3 pc == $past(rel_target, 3)) else $error("Signed branch wrong.");
  a_io_bit_set: assert property (accept && op_in == op_io_bit_set |-> ##3
    (opnd[`BSBE_F_IO] == ($past(io_v, 3) | $past(mask, 3)))) else $error("I/O bit set wrong.");
  a_shift_carry: assert property (accept && op_in == op_shift_left_logical |-> ##2
    (flags[`BSBE_FL_C] == $past(rd_v[7], 2) && !opnd[0])) else $error("Shift carry wrong.");
  a_int_return: assert property (accept && op_in == op_interrupt_return |-> ##5
    (flags[`BSBE_FL_I] && pc == $past(stack, 5))) else $error("Interrupt return wrong.");
  a_all_ones: assert property (accept && op_in == op_register_all_ones |-> ##2
    (opnd[`BSBE_F_RD] == 8'hff && flags == $past(flags, 2))) else $error("Set register wrong.");

  c_call_run: cover property (accept && op_in == op_relative_call ##4 !busy);
  c_skip_taken: cover property (accept && skip_cond && two_word);
  c_branch_taken: cover property (accept && is_br && br);
  c_write_stall: cover property (psel && penable && pwrite && busy && !pready);
endmodule

// [verification/bsbe_apb_host.sv]
// APB master model that stands in for the software side of the register window.
`timescale 1ns/1ps
module bsbe_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Holds the request until pready is sampled high or 100 cycles pass, then leaves one idle cycle.
  // Released address and data are inverted so stale values never look valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err, output logic late);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    late = (n >= 100);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

// [verification/branch_skip_bit_execute_bench.sv]
// Self-checking bench: a reference model of the execute block is compared at every result.
`timescale 1ns/1ps
`include "bsbe_regs.svh"
module branch_skip_bit_execute_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, late;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int err_count = 0;
  int check_count = 0;
  int fbt [25:42] = '{1, 1, 0, 0, 0, 0, 2, 2, 0, 0, 5, 5, 6, 6, 3, 3, 7, 7};
  int pol [25:42] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0};
  int rd, rr, io, imm, pc, z, st, fl, b, two, ku, ks;
  int npc, nst, nfl, nrd, nio, res, cyc, tk, chk, fm;

  bsbe_execute uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bsbe_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rdata, rerr, late);
    check("pready in time", {31'h0, late}, 32'h0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic int zn(input int r);
    return ((r == 0) ? 2 : 0) | (((r >> 7) & 1) << 2);
  endfunction

  // Reference model of one instruction, all in plain integers.
  function automatic void model(input int op);
    int c, r, s, ci, cond;
    c = fl & 1;
    npc = (pc + 1) & 16'hffff;
    nst = st;
    nfl = fl;
    nrd = rd;
    nio = io;
    fm = 255;
    cond = 0;
    case (op)
      0, 1: begin
        nrd = (op == 0) ? (rd & rd) : (rd ^ rd);
        nfl = (fl & 8'hf1) | zn(nrd);
      end
      2: nrd = 255;
      3, 5: npc = (pc + ks + 1) & 16'hffff;
      4, 6: npc = z;
      7, 8: npc = st;
      10, 11, 12: begin
        s = (op == 12) ? imm : rr;
        ci = (op == 11) ? c : 0;
        r = (rd - s - ci) & 255;
        nfl = (fl & 8'hd0) | zn(r) | ((rd < s + ci) ? 1 : 0) | (((rd & 15) < (s & 15) + ci) ? 32 : 0);
        nfl = nfl | ((((rd ^ s) & (rd ^ r) & 128) != 0) ? 8 : 0);
        if (op == 11 && (fl & 2) == 0) nfl = nfl & 8'hfd;
        fm = 8'hef;
      end
      19: nio = io | (1 << b);
      20: nio = io & ~(1 << b);
      21, 22, 23, 24: begin
        r = (op == 21) ? (rd << 1) : (op == 22) ? (rd >> 1) : (op == 23) ? ((rd << 1) | c) : ((rd >> 1) | (c << 7));
        ci = (op == 21 || op == 23) ? (rd >> 7) : (rd & 1);
        nrd = r & 255;
        nfl = (fl & 8'hf0) | zn(nrd) | ci | ((((nrd >> 7) ^ ci) & 1) << 3);
      end
      default: ;
    endcase
    if (op == 9) cond = (rd == rr);
    if (op == 13 || op == 14) cond = (((rd >> b) & 1) == op - 13);
    if (op == 15 || op == 16) cond = (((io >> b) & 1) == op - 15);
    if (op == 17 || op == 18) cond = (((fl >> b) & 1) == 18 - op);
    if (op >= 25) cond = ((((op == 33 || op == 34) ? ((fl >> 2) ^ (fl >> 3)) : (fl >> fbt[op])) & 1) == pol[op]);
    cyc = (op == 3 || op == 4 || op == 19 || op == 20) ? 2 : (op == 5 || op == 6) ? 3 : (op == 7 || op == 8) ? 4 : 1;
    if (cond && (op == 9 || (op >= 13 && op <= 16))) begin
      npc = (pc + 2 + two) & 16'hffff;
      cyc = 2 + two;
    end else if (cond) begin
      npc = (pc + ks + 1) & 16'hffff;
      cyc = 2;
    end
    tk = cond;
    if (op == 5 || op == 6) nst = (pc + 1) & 16'hffff;
    if (op == 8) nfl = fl | 128;
    res = nrd;
    chk = (op <= 2 || (op >= 21 && op <= 24));
  endfunction

  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #1_200_000;
    err_count++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    void'($urandom(32'hb498a027));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 24; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      check("reset value", rdata, 32'h0);
    end
    bus(1'b0, 8'h1c, 32'h0);
    check("unmapped error", {31'h0, rerr}, 32'h1);
    bus(1'b1, `BSBE_ADDR_RESULT, 32'hffff_ffff);
    check("result write error", {31'h0, rerr}, 32'h1);
    bus(1'b1, `BSBE_ADDR_INSTR, 32'h0000_002b);
    check("bad op error", {31'h0, rerr}, 32'h1);
    $display("test reset_and_refusal done");
    for (int op = 0; op <= 42; op++) begin
      repeat (6) begin
        rd = $urandom & 255;
        rr = (($urandom & 1) || op == 13 || op == 14) ? rd : ($urandom & 255);
        io = $urandom & 255;
        imm = ($urandom & 1) ? rd : ($urandom & 255);
        pc = $urandom & 16'hffff;
        z = $urandom & 16'hffff;
        st = $urandom & 16'hffff;
        fl = $urandom & 255;
        b = $urandom & 7;
        two = $urandom & 1;
        ku = $urandom & 4095;
        ks = (ku >= 2048) ? ku - 4096 : ku;
        model(op);
        bus(1'b1, `BSBE_ADDR_OPND, {imm[7:0], io[7:0], rr[7:0], rd[7:0]});
        bus(1'b1, `BSBE_ADDR_PC, 32'(pc));
        bus(1'b1, `BSBE_ADDR_STACK, 32'(st));
        bus(1'b1, `BSBE_ADDR_FLAGS, 32'(fl));
        bus(1'b1, `BSBE_ADDR_ZPTR, 32'(z));
        bus(1'b1, `BSBE_ADDR_INSTR, {4'h0, ku[11:0], 4'h0, two[0], b[2:0], 2'b00, op[5:0]});
        bus(1'b1, `BSBE_ADDR_ZPTR, 32'(z));
        bus(1'b0, `BSBE_ADDR_RESULT, 32'h0);
        check("busy after stall", {31'h0, rdata[8]}, 32'h0);
        check("cycle count", {29'h0, rdata[12:10]}, 32'(cyc));
        if (op == 9 || (op >= 13 && op <= 18) || op >= 25) check("taken", {31'h0, rdata[9]}, 32'(tk));
        if (chk) check("result", {24'h0, rdata[7:0]}, 32'(res));
        check("rd written", {31'h0, rdata[13]}, 32'(chk));
        check("io written", {31'h0, rdata[14]}, 32'(op == 19 || op == 20));
        bus(1'b0, `BSBE_ADDR_PC, 32'h0);
        check("pc", rdata, 32'(npc));
        bus(1'b0, `BSBE_ADDR_STACK, 32'h0);
        check("stack", rdata, 32'(nst));
        bus(1'b0, `BSBE_ADDR_FLAGS, 32'h0);
        check("flags", rdata & 32'(fm), 32'(nfl & fm));
        bus(1'b0, `BSBE_ADDR_OPND, 32'h0);
        check("operands", rdata, {imm[7:0], nio[7:0], rr[7:0], nrd[7:0]});
      end
    end
    $display("test instruction_sweep done");
    conclude();
  end
endmodule
